/* rtl/pmoc_map.vh */
// constants for the power-module command interpreter: command codes, field positions, reset values
// assumes a byte-level front end that has already framed the bus transaction
// Summary of operation
// - run-control bits 7:6: 00 immediate off, 01 soft off, 10 enable at margin
// - run-control bits 5:4: 00 nominal, 01 margin low, 10 margin high
// - run-control bits 3:2: 10 acts on voltage faults when margined, 01 ignores them
// - config bit 4 zero: run whenever powered, regardless of enable pin
// - config bit 3 zero: ignore run-control on/off field; one: require run
// - config bit 2 zero: ignore enable pin; one: pin must be asserted
// - config bit 1 is pin polarity: 0 active low, 1 active high
// - config bit 0 picks pin turn-off style: 0 soft, 1 immediate
// - fault-clear send-byte clears every fault status bit
// - every supported command stays readable whatever the write lock holds
// - lock 0x80 blocks all but lock; 0x40 adds run-control, page; 0x20 adds config, vout
// - lock 0x00 accepts writes to all commands but the read-only feature byte
// - store-default copies current configuration into the default store
// - restore-default reloads configuration from the default store
// - store-user saves settings changed since last restore into user store
// - restore-user reloads user store, also done automatically at power-up
// - read-only feature byte, bit 7 zero means no packet error checking
// - margin-high selects the separate margin-high target value
`ifndef PMOC_MAP_VH
`define PMOC_MAP_VH
`define PMOC_CMD_PAGE 8'h00
`define PMOC_CMD_RUN 8'h01
`define PMOC_CMD_CFG 8'h02
`define PMOC_CMD_CLRF 8'h03
`define PMOC_CMD_LOCK 8'h10
`define PMOC_CMD_STD 8'h11
`define PMOC_CMD_RSD 8'h12
`define PMOC_CMD_STU 8'h15
`define PMOC_CMD_RSU 8'h16
`define PMOC_CMD_FEAT 8'h19
`define PMOC_CMD_VOUT 8'h21
`define PMOC_CMD_MHI 8'h25
`define PMOC_CMD_MLO 8'h26
`define PMOC_LOCK_ALL 8'h80
`define PMOC_LOCK_OPER 8'h40
`define PMOC_LOCK_CTRL 8'h20
`define PMOC_LOCK_NONE 8'h00
`define PMOC_RUN_ON_HI 7
`define PMOC_RUN_ON_LO 6
`define PMOC_RUN_MG_HI 5
`define PMOC_RUN_MG_LO 4
`define PMOC_RUN_FA_HI 3
`define PMOC_RUN_FA_LO 2
`define PMOC_ON_IMM 2'h0
`define PMOC_ON_SOFT 2'h1
`define PMOC_ON_RUN 2'h2
`define PMOC_MG_NOM 2'h0
`define PMOC_MG_LOW 2'h1
`define PMOC_MG_HIGH 2'h2
`define PMOC_FA_IGN 2'h1
`define PMOC_FA_ACT 2'h2
`define PMOC_CFG_PWRUP 4
`define PMOC_CFG_BUS 3
`define PMOC_CFG_PIN 2
`define PMOC_CFG_POL 1
`define PMOC_CFG_IMM 0
`define PMOC_FEAT_PEC 7
`define PMOC_RST_RUN 8'h04
`define PMOC_RST_CFG 8'h1E
`define PMOC_RST_LOCK 8'h00
`define PMOC_RST_FEAT 8'h00
`define PMOC_RST_VOUT 16'h0000
`define PMOC_RST_MHI 16'h0000
`define PMOC_RST_MLO 16'h0000
`define PMOC_NV_RUN 2'h0
`define PMOC_NV_CFG 2'h1
`define PMOC_NV_LOCK 2'h2
`endif

/* rtl/pmoc_nv_store.v */
// small configuration store: two banks (default, user) of four bytes each
// assumes one write or one read per cycle; read data registered
`timescale 1ns/1ns
module pmoc_nv_store (
   input wire clock_i,
   input wire arst_n_i,
   input wire wr_en_i,
   input wire [2:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire [2:0] rd_addr_i,
   output reg [7:0] rd_data_o
);
`include "pmoc_map.vh"
   reg [7:0] mem_r [0:7];
   integer i;
   // reset models factory contents; both banks start at the configuration reset values
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem_r[i] <= 8'h00;
         end
         mem_r[0] <= `PMOC_RST_RUN;
         mem_r[1] <= `PMOC_RST_CFG;
         mem_r[4] <= `PMOC_RST_RUN;
         mem_r[5] <= `PMOC_RST_CFG;
         rd_data_o <= 8'h00;
      end else begin
         if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= mem_r[rd_addr_i];
      end
   end
endmodule

/* rtl/pmoc_cmd_ctrl.v */
// command interpreter for run/margin control, on/off sources, write lock, fault clear and store/restore
// assumes a framed byte front end: one-cycle cmd_valid_i with code and data; reads answered next cycle
`timescale 1ns/1ns
module pmoc_cmd_ctrl (
   input wire clock_i,
   input wire arst_n_i,
   input wire cmd_valid_i,
   input wire cmd_write_i,
   input wire cmd_send_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_data_i,
   input wire enable_pin_i,
   input wire power_ok_i,
   input wire fault_set_i,
   output reg [15:0] rd_data_o,
   output reg rd_valid_o,
   output reg busy_o,
   output reg comm_fault_o,
   output reg fault_o,
   output reg out_run_o,
   output reg off_imm_o,
   output reg [15:0] vout_target_o,
   output reg act_on_faults_o
);
`include "pmoc_map.vh"
   localparam ST_IDLE = 3'h0;
   localparam ST_BOOT = 3'h1;
   localparam ST_STORE = 3'h2;
   localparam ST_LOAD = 3'h3;
   localparam ST_LOADW = 3'h4;

   reg [7:0] run_r;
   reg [7:0] cfg_r;
   reg [7:0] lock_r;
   reg [15:0] vout_r;
   reg [15:0] mhi_r;
   reg [15:0] mlo_r;
   reg [2:0] dirty_r;
   reg [2:0] st_r;
   reg bank_r;
   reg [1:0] idx_r;
   reg [1:0] idx_d_r;
   reg store_user_r;
   reg comm_fault_r;

   wire nv_wr_en;
   wire [2:0] nv_wr_addr;
   wire [7:0] nv_wr_data;
   wire [2:0] nv_rd_addr;
   wire [7:0] nv_rd_data;
   reg [7:0] cur_byte;
   // slot 3 of each bank is spare; the store walk skips it and the restore stops before it

   always @* begin
      case (idx_r)
         `PMOC_NV_RUN: cur_byte = run_r;
         `PMOC_NV_CFG: cur_byte = cfg_r;
         `PMOC_NV_LOCK: cur_byte = lock_r;
         default: cur_byte = 8'h00;
      endcase
   end

   assign nv_wr_en = (st_r == ST_STORE) && (idx_r != 2'h3) && (!store_user_r || dirty_r[idx_r]);
   assign nv_wr_addr = {bank_r, idx_r};
   assign nv_wr_data = cur_byte;
   assign nv_rd_addr = {bank_r, idx_r};

   pmoc_nv_store u_store (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .wr_en_i(nv_wr_en),
      .wr_addr_i(nv_wr_addr),
      .wr_data_i(nv_wr_data),
      .rd_addr_i(nv_rd_addr),
      .rd_data_o(nv_rd_data)
   );

   reg wr_allowed;
   always @* begin
      case (lock_r)
         `PMOC_LOCK_NONE: wr_allowed = 1'b1;
         `PMOC_LOCK_CTRL: wr_allowed = (cmd_code_i == `PMOC_CMD_LOCK) || (cmd_code_i == `PMOC_CMD_RUN) ||
            (cmd_code_i == `PMOC_CMD_PAGE) || (cmd_code_i == `PMOC_CMD_CFG) || (cmd_code_i == `PMOC_CMD_VOUT);
         `PMOC_LOCK_OPER: wr_allowed = (cmd_code_i == `PMOC_CMD_LOCK) || (cmd_code_i == `PMOC_CMD_RUN) ||
            (cmd_code_i == `PMOC_CMD_PAGE);
         // the lock stays writable at every level, else a locked part could never be opened
         `PMOC_LOCK_ALL: wr_allowed = (cmd_code_i == `PMOC_CMD_LOCK);
         // other lock values treated as open
         default: wr_allowed = 1'b1;
      endcase
   end

   wire run_ok = (cmd_data_i[`PMOC_RUN_ON_HI:`PMOC_RUN_ON_LO] != 2'h3) &&
      (cmd_data_i[`PMOC_RUN_MG_HI:`PMOC_RUN_MG_LO] != 2'h3) &&
      ((cmd_data_i[`PMOC_RUN_FA_HI:`PMOC_RUN_FA_LO] == `PMOC_FA_IGN) ||
      (cmd_data_i[`PMOC_RUN_FA_HI:`PMOC_RUN_FA_LO] == `PMOC_FA_ACT));
   wire is_sendcmd = (cmd_code_i == `PMOC_CMD_CLRF) || (cmd_code_i == `PMOC_CMD_STD) ||
      (cmd_code_i == `PMOC_CMD_RSD) || (cmd_code_i == `PMOC_CMD_STU) || (cmd_code_i == `PMOC_CMD_RSU);
   // commands are only taken while the sequencer is idle; the busy term of bad_cmd catches the rest
   wire take_wr = cmd_valid_i && cmd_write_i && (st_r == ST_IDLE);
   wire take_send = cmd_valid_i && cmd_send_i && (st_r == ST_IDLE);
   // store commands write the nonvolatile banks, so the lock guards them too; fault clear is always allowed
   wire send_ok = wr_allowed || (cmd_code_i == `PMOC_CMD_CLRF);
   wire bad_cmd = (take_wr && (!wr_allowed || (cmd_code_i == `PMOC_CMD_RUN && !run_ok) ||
      cmd_code_i == `PMOC_CMD_FEAT)) || (take_send && (!is_sendcmd || !send_ok)) ||
      (cmd_valid_i && st_r != ST_IDLE);
   wire good_wr = take_wr && !bad_cmd;
   wire good_send = take_send && !bad_cmd;

   // busy follows the next sequencer state, so it drops in the very cycle commands are taken again
   wire seq_last = ((st_r == ST_STORE) && (idx_r == 2'h3)) || ((st_r == ST_LOADW) && (idx_r == 2'h2));
   wire seq_start = good_send && (cmd_code_i != `PMOC_CMD_CLRF);
   wire busy_nxt = ((st_r != ST_IDLE) && !seq_last) || seq_start;

   // control and store sequencer
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_r <= `PMOC_RST_RUN;
         cfg_r <= `PMOC_RST_CFG;
         lock_r <= `PMOC_RST_LOCK;
         vout_r <= `PMOC_RST_VOUT;
         mhi_r <= `PMOC_RST_MHI;
         mlo_r <= `PMOC_RST_MLO;
         dirty_r <= 3'h0;
         // restore user at power-up
         // both stores reload their factory contents on this reset too, so the power-up restore brings back factory values
         st_r <= ST_BOOT;
         bank_r <= 1'b1;
         idx_r <= 2'h0;
         idx_d_r <= 2'h0;
         store_user_r <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (good_wr) begin
                  case (cmd_code_i)
                     `PMOC_CMD_RUN: begin
                        run_r <= cmd_data_i[7:0];
                        dirty_r[0] <= 1'b1;
                     end
                     `PMOC_CMD_CFG: begin
                        cfg_r <= cmd_data_i[7:0];
                        dirty_r[1] <= 1'b1;
                     end
                     `PMOC_CMD_LOCK: begin
                        lock_r <= cmd_data_i[7:0];
                        dirty_r[2] <= 1'b1;
                     end
                     `PMOC_CMD_VOUT: vout_r <= cmd_data_i;
                     `PMOC_CMD_MHI: mhi_r <= cmd_data_i;
                     `PMOC_CMD_MLO: mlo_r <= cmd_data_i;
                     default: ;
                  endcase
               end
               if (good_send) begin
                  idx_r <= 2'h0;
                  case (cmd_code_i)
                     `PMOC_CMD_STD: begin
                        st_r <= ST_STORE;
                        bank_r <= 1'b0;
                        store_user_r <= 1'b0;
                     end
                     `PMOC_CMD_STU: begin
                        st_r <= ST_STORE;
                        bank_r <= 1'b1;
                        store_user_r <= 1'b1;
                     end
                     `PMOC_CMD_RSD: begin
                        st_r <= ST_LOAD;
                        bank_r <= 1'b0;
                     end
                     `PMOC_CMD_RSU: begin
                        st_r <= ST_LOAD;
                        bank_r <= 1'b1;
                     end
                     default: ;
                  endcase
               end
            end
            ST_BOOT: begin
               idx_r <= 2'h0;
               st_r <= ST_LOAD;
            end
            ST_STORE: begin
               idx_r <= idx_r + 2'h1;
               if (idx_r == 2'h3) begin
                  st_r <= ST_IDLE;
               end
            end
            // registered read: address in one cycle, data the next
            ST_LOAD: begin
               idx_d_r <= idx_r;
               st_r <= ST_LOADW;
            end
            ST_LOADW: begin
               case (idx_d_r)
                  `PMOC_NV_RUN: run_r <= nv_rd_data;
                  `PMOC_NV_CFG: cfg_r <= nv_rd_data;
                  `PMOC_NV_LOCK: lock_r <= nv_rd_data;
                  default: ;
               endcase
               if (idx_r == 2'h2) begin
                  st_r <= ST_IDLE;
                  // nothing stays pending for a later store-user once a restore is done
                  dirty_r <= 3'h0;
               end else begin
                  idx_r <= idx_r + 2'h1;
                  st_r <= ST_LOAD;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   wire pin_on = cfg_r[`PMOC_CFG_POL] ? enable_pin_i : !enable_pin_i;
   wire bus_on = run_r[`PMOC_RUN_ON_HI:`PMOC_RUN_ON_LO] == `PMOC_ON_RUN;

   wire run_req = (!cfg_r[`PMOC_CFG_BUS] || bus_on) && (!cfg_r[`PMOC_CFG_PIN] || pin_on);

   wire run_want = power_ok_i && (!cfg_r[`PMOC_CFG_PWRUP] || run_req);
   // pin-off takes the pin style, otherwise the bus field decides
   wire pin_off = cfg_r[`PMOC_CFG_PWRUP] && cfg_r[`PMOC_CFG_PIN] && !pin_on;

   reg [7:0] rd_mux;
   always @* begin
      case (cmd_code_i)
         `PMOC_CMD_RUN: rd_mux = run_r;
         `PMOC_CMD_CFG: rd_mux = cfg_r;
         `PMOC_CMD_LOCK: rd_mux = lock_r;
         `PMOC_CMD_FEAT: rd_mux = `PMOC_RST_FEAT;
         default: rd_mux = 8'h00;
      endcase
   end

   reg [15:0] rd_word;
   always @* begin
      case (cmd_code_i)
         `PMOC_CMD_VOUT: rd_word = vout_r;
         `PMOC_CMD_MHI: rd_word = mhi_r;
         `PMOC_CMD_MLO: rd_word = mlo_r;
         default: rd_word = {8'h00, rd_mux};
      endcase
   end

   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
         busy_o <= 1'b1;
         comm_fault_o <= 1'b0;
         comm_fault_r <= 1'b0;
         fault_o <= 1'b0;
         out_run_o <= 1'b0;
         off_imm_o <= 1'b0;
         vout_target_o <= `PMOC_RST_VOUT;
         act_on_faults_o <= 1'b1;
      end else begin
         // a read during a store or restore is still answered, but it counts as a refused command
         rd_valid_o <= cmd_valid_i && !cmd_write_i && !cmd_send_i;
         rd_data_o <= (cmd_valid_i && !cmd_write_i && !cmd_send_i) ? rd_word : 16'h0000;
         busy_o <= busy_nxt;
         // clear all faults; new fault wins
         // a clear that meets a new fault in one cycle is lost, so the host never misses that fault
         if (bad_cmd || fault_set_i) begin
            comm_fault_r <= bad_cmd | comm_fault_r;
            comm_fault_o <= bad_cmd | comm_fault_r;
            fault_o <= 1'b1;
         end else if (good_send && cmd_code_i == `PMOC_CMD_CLRF) begin
            comm_fault_r <= 1'b0;
            comm_fault_o <= 1'b0;
            fault_o <= 1'b0;
         end
         out_run_o <= run_want;
         off_imm_o <= pin_off ? cfg_r[`PMOC_CFG_IMM] : (run_r[`PMOC_RUN_ON_HI:`PMOC_RUN_ON_LO] == `PMOC_ON_IMM);
         case (run_r[`PMOC_RUN_MG_HI:`PMOC_RUN_MG_LO])
            `PMOC_MG_LOW: vout_target_o <= mlo_r;
            `PMOC_MG_HIGH: vout_target_o <= mhi_r;
            default: vout_target_o <= vout_r;
         endcase
         act_on_faults_o <= (run_r[`PMOC_RUN_MG_HI:`PMOC_RUN_MG_LO] == `PMOC_MG_NOM) ||
            (run_r[`PMOC_RUN_FA_HI:`PMOC_RUN_FA_LO] == `PMOC_FA_ACT);
      end
   end
endmodule

/* verification/pmoc_cmd_props.sv */
// port assertions for the command interpreter
// assumes one clock domain; bound onto every pmoc_cmd_ctrl
`timescale 1ns/1ns
module pmoc_cmd_props (
   input wire clock_i,
   input wire arst_n_i,
   input wire cmd_valid_i,
   input wire cmd_write_i,
   input wire cmd_send_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_data_i,
   input wire fault_set_i,
   input wire [15:0] rd_data_o,
   input wire rd_valid_o,
   input wire busy_o,
   input wire comm_fault_o,
   input wire fault_o,
   input wire act_on_faults_o
);
   wire rd_req = cmd_valid_i && !cmd_write_i && !cmd_send_i;
   wire clr = cmd_valid_i && cmd_send_i && cmd_code_i == 8'h03;
   wire run_wr = cmd_valid_i && cmd_write_i && cmd_code_i == 8'h01 && !comm_fault_o;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);
   a_read_answer: assert property (rd_req && !busy_o |=> rd_valid_o)
      else $error("read left unanswered");
   a_no_stray_read: assert property (rd_valid_o |-> $past(rd_req))
      else $error("answer without a read");
   a_feat_zero: assert property (rd_valid_o && $past(cmd_code_i) == 8'h19 |-> rd_data_o == 16'h0000)
      else $error("feature byte not zero");
   a_feat_locked: assert property (cmd_valid_i && cmd_write_i && cmd_code_i == 8'h19 |=> comm_fault_o)
      else $error("feature write not refused");
   a_busy_refuse: assert property (busy_o && cmd_valid_i && !clr |=> comm_fault_o)
      else $error("command taken while busy");
   a_fault_clear: assert property (clr && !busy_o && !fault_set_i |=> !comm_fault_o && !fault_o)
      else $error("faults not cleared");
   a_fault_hold: assert property (comm_fault_o && !clr |=> comm_fault_o)
      else $error("comm fault dropped");
   a_fault_pulse: assert property (fault_set_i |=> fault_o)
      else $error("fault not latched");
   a_ignore_margin: assert property (run_wr && cmd_data_i[5:2] == 4'h9 ##1 !comm_fault_o |=> !act_on_faults_o)
      else $error("margined faults not ignored");
   a_act_nominal: assert property (run_wr && cmd_data_i[5:4] == 2'h0 ##1 !comm_fault_o |=> act_on_faults_o)
      else $error("nominal faults not acted on");
endmodule
bind pmoc_cmd_ctrl pmoc_cmd_props pmoc_cmd_props_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
   .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_send_i(cmd_send_i), .cmd_code_i(cmd_code_i),
   .cmd_data_i(cmd_data_i), .fault_set_i(fault_set_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .busy_o(busy_o), .comm_fault_o(comm_fault_o), .fault_o(fault_o), .act_on_faults_o(act_on_faults_o));

/* verification/pmoc_host_model.sv */
// host controller model: one framed command at a time
// assumes the design answers reads within three cycles
`timescale 1ns/1ns
module pmoc_host_model (
   input wire clock_i,
   input wire rd_valid_i,
   input wire [15:0] rd_data_i,
   output reg cmd_valid_o,
   output reg cmd_write_o,
   output reg cmd_send_o,
   output reg [7:0] cmd_code_o,
   output reg [15:0] cmd_data_o
);
   initial begin
      {cmd_valid_o, cmd_write_o, cmd_send_o} = 3'h0;
      {cmd_code_o, cmd_data_o} = 24'h000000;
   end
   // kind 0 read, 1 write, 2 send; ok stays low when a read goes unanswered
   task xfer(input integer kind, input [7:0] code, input [15:0] data, output [15:0] rdata, output ok);
      integer n;
      begin
         @(negedge clock_i);
         {cmd_valid_o, cmd_write_o, cmd_send_o} = {1'b1, kind == 1, kind == 2};
         {cmd_code_o, cmd_data_o} = {code, data};
         @(negedge clock_i);
         {cmd_valid_o, cmd_write_o, cmd_send_o} = 3'h0;
         // released lines flip so a stale value is never taken for a live one
         {cmd_code_o, cmd_data_o} = ~{code, data};
         ok = kind != 0;
         rdata = 16'h0000;
         for (n = 0; n < 3 && !ok; n = n + 1) begin
            if (rd_valid_i === 1'b1)
               {ok, rdata} = {1'b1, rd_data_i};
            else
               @(negedge clock_i);
         end
      end
   endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench: host model drives commands, integer model predicts every result
// assumes checker, host model and design are compiled before it
`timescale 1ns/1ns
module tb_top;
   reg clock_i, arst_n_i, enable_pin_i, power_ok_i, fault_set_i, fast, busy_m, ok;
   wire cv, cw, cs, rd_valid_o, busy_o, comm_fault_o, fault_o, out_run_o, off_imm_o, act_on_faults_o;
   wire [7:0] cc;
   wire [15:0] cd, rd_data_o, vout_target_o;
   reg [31:0] seed;
   reg [15:0] rd, v, d;
   reg [7:0] c, cur [0:2], u_st [0:2], d_st [0:2];
   reg dirty [0:2];
   integer fail_count, checked, i, j, k, n, m_vout, m_mhi, m_mlo, m_cf, m_f;
   pmoc_cmd_ctrl pmoc_cmd_ctrl_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .cmd_valid_i(cv), .cmd_write_i(cw),
      .cmd_send_i(cs), .cmd_code_i(cc), .cmd_data_i(cd), .enable_pin_i(enable_pin_i), .power_ok_i(power_ok_i),
      .fault_set_i(fault_set_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .busy_o(busy_o),
      .comm_fault_o(comm_fault_o), .fault_o(fault_o), .out_run_o(out_run_o), .off_imm_o(off_imm_o),
      .vout_target_o(vout_target_o), .act_on_faults_o(act_on_faults_o));
   pmoc_host_model pmoc_host_model_inst (.clock_i(clock_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
      .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_send_o(cs), .cmd_code_o(cc), .cmd_data_o(cd));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [7:0] addr(input integer x);
      addr = x == 0 ? 8'h01 : x == 1 ? 8'h02 : 8'h10;
   endfunction
   function allow(input [7:0] a);
      allow = cur[2] == 8'h80 ? a == 8'h10 : cur[2] == 8'h40 ? a == 8'h10 || a <= 8'h01 :
         cur[2] == 8'h20 ? a == 8'h10 || a <= 8'h02 || a == 8'h21 : 1'b1;
   endfunction
   task check(input [95:0] name, input [15:0] exp, input [15:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wait_idle;
      begin
         for (k = 0; busy_o !== 1'b0 && k < 40; k = k + 1)
            @(negedge clock_i);
         if (k == 40) begin
            fail_count = fail_count + 1;
            results;
         end
      end
   endtask
   task cmd(input integer kind, input [7:0] a, input [15:0] w);
      reg acc;
      begin
         pmoc_host_model_inst.xfer(kind, a, w, rd, ok);
         acc = !busy_m && (kind == 0 || a == 8'h03 || allow(a) && a != 8'h19);
         if (kind == 1 && a == 8'h01 && (w[7:6] == 2'h3 || w[5:4] == 2'h3 || w[3:2] == 2'h0 || w[3:2] == 2'h3))
            acc = 1'b0;
         busy_m = fast;
         v = a == 8'h21 ? m_vout : a == 8'h25 ? m_mhi : a == 8'h26 ? m_mlo : 16'h0000;
         for (j = 0; j < 3; j = j + 1) begin
            if (a == addr(j))
               v = {8'h00, cur[j]};
            if (acc && kind == 1 && a == addr(j))
               {cur[j], dirty[j]} = {w[7:0], 1'b1};
            if (acc && kind == 2 && a == 8'h11)
               d_st[j] = cur[j];
            if (acc && kind == 2 && a == 8'h15 && dirty[j])
               u_st[j] = cur[j];
            if (acc && kind == 2 && (a == 8'h12 || a == 8'h16))
               {cur[j], dirty[j]} = {a == 8'h12 ? d_st[j] : u_st[j], 1'b0};
         end
         if (acc && kind == 1 && a[7:4] == 4'h2)
            {m_vout, m_mhi, m_mlo} = {a == 8'h21 ? w : m_vout, a == 8'h25 ? w : m_mhi, a == 8'h26 ? w : m_mlo};
         if (!acc)
            m_cf = 1;
         if (acc && a == 8'h03 && kind == 2)
            {m_cf, m_f} = 0;
         m_f = m_f | m_cf;
         if (!fast) begin
            repeat (2) @(negedge clock_i);
            wait_idle;
         end
         if (kind == 0 && acc) begin
            check("answered", 16'h0001, ok);
            check("read data", v, rd);
         end
         check("comm fault", m_cf, comm_fault_o);
         check("fault", m_f, fault_o);
      end
   endtask
   task chk_out;
      reg pin_ok, bus_ok;
      begin
         pin_ok = !cur[1][4] || !cur[1][2] || enable_pin_i == cur[1][1];
         bus_ok = !cur[1][4] || !cur[1][3] || cur[0][7:6] == 2'h2;
         check("run", pin_ok && bus_ok && power_ok_i, out_run_o);
         if (pin_ok != bus_ok)
            check("off style", bus_ok ? cur[1][0] : cur[0][7:6] == 2'h0, off_imm_o);
         v = cur[0][5:4] == 2'h1 ? m_mlo : cur[0][5:4] == 2'h2 ? m_mhi : m_vout;
         check("target", v, vout_target_o);
         check("act faults", cur[0][5:4] == 2'h0 || cur[0][3:2] == 2'h2, act_on_faults_o);
      end
   endtask
   initial begin
      {arst_n_i, enable_pin_i, power_ok_i, fault_set_i, fast, busy_m} = 6'h08;
      {fail_count, checked, m_vout, m_mhi, m_mlo, m_cf, m_f} = 0;
      seed = 32'hF7A4;
      for (j = 0; j < 3; j = j + 1)
         {cur[j], dirty[j]} = {j == 0 ? 8'h04 : j == 1 ? 8'h1E : 8'h00, 1'b0};
      repeat (4) @(negedge clock_i);
      arst_n_i = 1'b1;
      repeat (2) @(negedge clock_i);
      wait_idle;
      cmd(1, 8'h21, 16'h1234);
      cmd(1, 8'h25, 16'h5A5A);
      cmd(1, 8'h26, 16'h0F0F);
      cmd(0, 8'h19, 16'h0000);
      cmd(1, 8'h19, 16'h0080);
      cmd(2, 8'h03, 16'h0000);
      for (i = 0; i < 16; i = i + 1) begin
         cmd(1, 8'h01, {8'h00, 2'h2, i[3:0], 2'h0});
         chk_out;
         cmd(2, 8'h03, 16'h0000);
      end
      for (i = 0; i < 48; i = i + 1) begin
         seed = lfsr(seed);
         enable_pin_i = seed[0];
         cmd(1, 8'h02, {11'h000, seed[5:1]});
         cmd(1, 8'h01, {8'h00, seed[7:6], 2'h0, seed[8], ~seed[8], 2'h0});
         chk_out;
      end
      for (i = 0; i < 4; i = i + 1) begin
         cmd(1, 8'h10, {8'h00, i == 3 ? 8'h00 : 8'h80 >> i});
         for (n = 0; n < 4; n = n + 1) begin
            seed = lfsr(seed);
            c = n == 0 ? 8'h01 : n == 1 ? 8'h02 : n == 2 ? 8'h21 : 8'h25;
            d = n == 0 ? {12'h008, seed[0], ~seed[0], 2'h0} : n == 1 ? {11'h000, seed[4:0]} : seed[15:0];
            cmd(1, c, d);
            cmd(0, c, 16'h0000);
         end
         cmd(2, 8'h11, 16'h0000);
         cmd(0, 8'h10, 16'h0000);
         cmd(2, 8'h03, 16'h0000);
      end
      cmd(1, 8'h02, 16'h0016);
      cmd(2, 8'h15, 16'h0000);
      cmd(1, 8'h02, 16'h0008);
      cmd(1, 8'h01, 16'h0098);
      cmd(2, 8'h16, 16'h0000);
      cmd(0, 8'h02, 16'h0000);
      cmd(1, 8'h01, 16'h0084);
      cmd(2, 8'h15, 16'h0000);
      cmd(2, 8'h12, 16'h0000);
      for (n = 0; n < 3; n = n + 1)
         cmd(0, addr(n), 16'h0000);
      cmd(2, 8'h16, 16'h0000);
      cmd(0, 8'h01, 16'h0000);
      fast = 1'b1;
      cmd(2, 8'h15, 16'h0000);
      fast = 1'b0;
      cmd(1, 8'h02, 16'h0004);
      fault_set_i = 1'b1;
      @(negedge clock_i);
      fault_set_i = 1'b0;
      m_f = 1;
      cmd(0, 8'h19, 16'h0000);
      cmd(2, 8'h03, 16'h0000);
      results;
   end
endmodule
